/* design/ccmt_pkg.sv */
package ccmt_pkg;

   // machine cycle and timer rates in oscillator clocks, instruction limits in machine cycles
   localparam logic [1:0] CCMT_LAST_PHASE = 2'h3;
   localparam logic [3:0] CCMT_SLOW_TICK = 4'hC;
   localparam logic [3:0] CCMT_FAST_TICK = 4'h4;
   localparam logic [2:0] CCMT_MAX_CYCLES = 3'h5;
   localparam logic [1:0] CCMT_MAX_FETCH = 2'h3;
   localparam logic [1:0] CCMT_MAX_DATA = 2'h2;

   // register offsets
   localparam logic [7:0] CCMT_OFF_PORT0 = 8'h80;
   localparam logic [7:0] CCMT_OFF_SP = 8'h81;
   localparam logic [7:0] CCMT_OFF_DPTR_LO = 8'h82;
   localparam logic [7:0] CCMT_OFF_DPTR_HI = 8'h83;
   localparam logic [7:0] CCMT_OFF_PTR2_LO = 8'h84;
   localparam logic [7:0] CCMT_OFF_PTR2_HI = 8'h85;
   localparam logic [7:0] CCMT_OFF_PTR_SEL = 8'h86;
   localparam logic [7:0] CCMT_OFF_PWR = 8'h87;
   localparam logic [7:0] CCMT_OFF_TMR_CTL = 8'h88;
   localparam logic [7:0] CCMT_OFF_TMR_MODE = 8'h89;
   localparam logic [7:0] CCMT_OFF_TMR0_LO = 8'h8A;
   localparam logic [7:0] CCMT_OFF_TMR1_LO = 8'h8B;
   localparam logic [7:0] CCMT_OFF_TMR0_HI = 8'h8C;
   localparam logic [7:0] CCMT_OFF_TMR1_HI = 8'h8D;
   localparam logic [7:0] CCMT_OFF_CLK_SPEED = 8'h8E;
   localparam logic [7:0] CCMT_OFF_SEQ_STATUS = 8'h8F;
   localparam logic [7:0] CCMT_OFF_PORT_1_LATCH = 8'h90;
   localparam logic [7:0] CCMT_OFF_EXT_IRQ = 8'h91;
   localparam logic [7:0] CCMT_OFF_SER0_CTL = 8'h98;
   localparam logic [7:0] CCMT_OFF_SER0_BUF = 8'h99;
   localparam logic [7:0] CCMT_OFF_PORT2 = 8'hA0;
   localparam logic [7:0] CCMT_OFF_IRQ_EN = 8'hA8;
   localparam logic [7:0] CCMT_OFF_SER0_ADDR = 8'hA9;

   // field positions and timer count
   localparam int CCMT_PTR_SEL_BIT = 0;
   localparam int CCMT_T0_RATE_BIT = 3;
   localparam int CCMT_TIMER_COUNT = 3;

   // reset values
   localparam logic [7:0] CCMT_RST_PORT = 8'hFF;
   localparam logic [7:0] CCMT_RST_DEFAULT = 8'h00;

   typedef enum logic {CCMT_IDLE, CCMT_RUN} ccmt_seq_t;
   typedef enum logic [1:0] {CCMT_K_NONE, CCMT_K_FETCH, CCMT_K_DATA, CCMT_K_INT} ccmt_kind_t;

endpackage : ccmt_pkg

/* design/ccmt_rate_tick.sv */
`timescale 1ns/1ps
module ccmt_rate_tick (
   input wire logic mclk,
   input wire logic sys_rst,
   input wire logic fastSel,
   output logic tick
);

   typedef struct packed {
      logic [3:0] cnt;
      logic tick;
   } ccmt_tick_t;

   ccmt_tick_t q_r;
   ccmt_tick_t q_nxt;
   logic [3:0] limit;

   always_comb begin
      q_nxt = q_r;
      limit = fastSel ? (ccmt_pkg::CCMT_FAST_TICK - 4'h1) : (ccmt_pkg::CCMT_SLOW_TICK - 4'h1);
      // a rate change mid-count wraps at once rather than running to 15
      if (q_r.cnt >= limit) begin
         q_nxt.cnt = 4'h0;
         q_nxt.tick = 1'b1;
      end else begin
         q_nxt.cnt = q_r.cnt + 4'h1;
         q_nxt.tick = 1'b0;
      end
   end

   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         q_r <= '0;
      end else begin
         q_r <= q_nxt;
      end
   end

   assign tick = q_r.tick;

endmodule : ccmt_rate_tick

/* design/ccmt_core_timing.sv */
`timescale 1ns/1ps
module ccmt_core_timing (
   input wire logic mclk,
   input wire logic sys_rst,
   input wire logic [7:0] regAddr,
   input wire logic [7:0] regWrData,
   input wire logic regWr,
   input wire logic regRd,
   output logic [7:0] regRdData,
   input wire logic insnStart,
   input wire logic [1:0] insnBytes,
   input wire logic [1:0] insnDataCyc,
   input wire logic [2:0] insnIntCyc,
   output logic insnReady,
   output logic insnDone,
   output logic busFetch,
   output logic busData,
   output logic ale,
   output logic [1:0] machPhase,
   input wire logic dptrInc,
   output logic [15:0] dptrOut,
   output logic [2:0] timerTick
);

   localparam int SFR_COUNT = 22;

   typedef struct packed {
      logic [1:0] phase;
      logic ale;
      ccmt_pkg::ccmt_seq_t state;
      ccmt_pkg::ccmt_kind_t kind;
      logic [1:0] fetchLeft;
      logic [1:0] dataLeft;
      logic [2:0] intLeft;
      logic [2:0] lenCnt;
      logic [7:0] rdData;
      logic [SFR_COUNT-1:0][7:0] sfr;
   } ccmt_core_t;

   // bit 5 is the hit flag, bits 4:0 the slot
   function automatic logic [5:0] sfrIdx(input logic [7:0] a);
      logic [5:0] r;
      r = 6'h00;
      case (a)
         ccmt_pkg::CCMT_OFF_PORT0: r = 6'h20;
         ccmt_pkg::CCMT_OFF_SP: r = 6'h21;
         ccmt_pkg::CCMT_OFF_DPTR_LO: r = 6'h22;
         ccmt_pkg::CCMT_OFF_DPTR_HI: r = 6'h23;
         ccmt_pkg::CCMT_OFF_PTR2_LO: r = 6'h24;
         ccmt_pkg::CCMT_OFF_PTR2_HI: r = 6'h25;
         ccmt_pkg::CCMT_OFF_PTR_SEL: r = 6'h26;
         ccmt_pkg::CCMT_OFF_PWR: r = 6'h27;
         ccmt_pkg::CCMT_OFF_TMR_CTL: r = 6'h28;
         ccmt_pkg::CCMT_OFF_TMR_MODE: r = 6'h29;
         ccmt_pkg::CCMT_OFF_TMR0_LO: r = 6'h2A;
         ccmt_pkg::CCMT_OFF_TMR1_LO: r = 6'h2B;
         ccmt_pkg::CCMT_OFF_TMR0_HI: r = 6'h2C;
         ccmt_pkg::CCMT_OFF_TMR1_HI: r = 6'h2D;
         ccmt_pkg::CCMT_OFF_CLK_SPEED: r = 6'h2E;
         ccmt_pkg::CCMT_OFF_PORT_1_LATCH: r = 6'h2F;
         ccmt_pkg::CCMT_OFF_EXT_IRQ: r = 6'h30;
         ccmt_pkg::CCMT_OFF_SER0_CTL: r = 6'h31;
         ccmt_pkg::CCMT_OFF_SER0_BUF: r = 6'h32;
         ccmt_pkg::CCMT_OFF_PORT2: r = 6'h33;
         ccmt_pkg::CCMT_OFF_IRQ_EN: r = 6'h34;
         ccmt_pkg::CCMT_OFF_SER0_ADDR: r = 6'h35;
         default: r = 6'h00;
      endcase
      return r;
   endfunction : sfrIdx

   // fetch cycles first, then data cycles, then internal ones
   function automatic ccmt_pkg::ccmt_kind_t nextKind(input logic [1:0] f, input logic [1:0] d,
                                                      input logic [2:0] i);
      ccmt_pkg::ccmt_kind_t k;
      k = ccmt_pkg::CCMT_K_NONE;
      if (f != 2'h0) begin
         k = ccmt_pkg::CCMT_K_FETCH;
      end else if (d != 2'h0) begin
         k = ccmt_pkg::CCMT_K_DATA;
      end else if (i != 3'h0) begin
         k = ccmt_pkg::CCMT_K_INT;
      end
      return k;
   endfunction : nextKind

   localparam logic [4:0] IDX_P0 = 5'(sfrIdx(ccmt_pkg::CCMT_OFF_PORT0));
   localparam logic [4:0] IDX_P1 = 5'(sfrIdx(ccmt_pkg::CCMT_OFF_PORT_1_LATCH));
   localparam logic [4:0] IDX_P2 = 5'(sfrIdx(ccmt_pkg::CCMT_OFF_PORT2));
   localparam logic [4:0] IDX_DPL = 5'(sfrIdx(ccmt_pkg::CCMT_OFF_DPTR_LO));
   localparam logic [4:0] IDX_DPH = 5'(sfrIdx(ccmt_pkg::CCMT_OFF_DPTR_HI));
   localparam logic [4:0] IDX_PL2 = 5'(sfrIdx(ccmt_pkg::CCMT_OFF_PTR2_LO));
   localparam logic [4:0] IDX_PH2 = 5'(sfrIdx(ccmt_pkg::CCMT_OFF_PTR2_HI));
   localparam logic [4:0] IDX_SEL = 5'(sfrIdx(ccmt_pkg::CCMT_OFF_PTR_SEL));
   localparam logic [4:0] IDX_CKS = 5'(sfrIdx(ccmt_pkg::CCMT_OFF_CLK_SPEED));

   ccmt_core_t q_r;
   ccmt_core_t q_nxt;
   logic busy;
   logic lastCyc;
   logic take;
   logic ptrSel;
   logic [2:0] timerFast;
   logic [5:0] wrHit;
   logic [5:0] rdHit;

   assign busy = (q_r.state == ccmt_pkg::CCMT_RUN);
   assign lastCyc = ({1'b0, q_r.fetchLeft} + {1'b0, q_r.dataLeft} + q_r.intLeft) == 3'h1;
   assign insnReady = (q_r.phase == ccmt_pkg::CCMT_LAST_PHASE) && (!busy || lastCyc);
   assign insnDone = busy && (q_r.phase == ccmt_pkg::CCMT_LAST_PHASE) && lastCyc;
   assign take = insnStart && insnReady;
   assign ptrSel = q_r.sfr[IDX_SEL][ccmt_pkg::CCMT_PTR_SEL_BIT];
   assign wrHit = sfrIdx(regAddr);
   assign rdHit = sfrIdx(regAddr);

   always_comb begin
      logic [1:0] f;
      logic [1:0] d;
      logic [2:0] i;
      logic [15:0] ptr;
      f = 2'h0;
      d = 2'h0;
      i = 3'h0;
      ptr = 16'h0000;
      q_nxt = q_r;
      // free-running phase; no instruction ever stretches a cycle
      q_nxt.phase = q_r.phase + 2'h1;
      q_nxt.ale = (q_r.phase == ccmt_pkg::CCMT_LAST_PHASE);

      if (busy && q_r.phase == ccmt_pkg::CCMT_LAST_PHASE) begin
         case (q_r.kind)
            ccmt_pkg::CCMT_K_FETCH: q_nxt.fetchLeft = q_r.fetchLeft - 2'h1;
            ccmt_pkg::CCMT_K_DATA: q_nxt.dataLeft = q_r.dataLeft - 2'h1;
            ccmt_pkg::CCMT_K_INT: q_nxt.intLeft = q_r.intLeft - 3'h1;
            default: q_nxt.intLeft = 3'h0;
         endcase
         if (lastCyc) begin
            q_nxt.state = ccmt_pkg::CCMT_IDLE;
            q_nxt.kind = ccmt_pkg::CCMT_K_NONE;
         end else begin
            q_nxt.kind = nextKind(q_nxt.fetchLeft, q_nxt.dataLeft, q_nxt.intLeft);
            q_nxt.lenCnt = q_r.lenCnt + 3'h1;
         end
      end

      if (take) begin
         // at least one byte, and the total clipped to five cycles
         f = (insnBytes == 2'h0) ? 2'h1 : insnBytes;
         d = (insnDataCyc > ccmt_pkg::CCMT_MAX_DATA) ? ccmt_pkg::CCMT_MAX_DATA : insnDataCyc;
         i = insnIntCyc;
         // four bits, so three bytes plus seven internal cycles cannot wrap
         if (({2'b00, f} + {2'b00, d} + {1'b0, i}) > {1'b0, ccmt_pkg::CCMT_MAX_CYCLES}) begin
            i = ccmt_pkg::CCMT_MAX_CYCLES - {1'b0, f} - {1'b0, d};
         end
         q_nxt.fetchLeft = f;
         q_nxt.dataLeft = d;
         q_nxt.intLeft = i;
         q_nxt.state = ccmt_pkg::CCMT_RUN;
         q_nxt.kind = nextKind(f, d, i);
         q_nxt.lenCnt = 3'h1;
      end

      // pointer increment touches no flags, wraps at 16 bits
      if (dptrInc) begin
         if (ptrSel) begin
            ptr = {q_r.sfr[IDX_PH2], q_r.sfr[IDX_PL2]} + 16'h0001;
            q_nxt.sfr[IDX_PH2] = ptr[15:8];
            q_nxt.sfr[IDX_PL2] = ptr[7:0];
         end else begin
            ptr = {q_r.sfr[IDX_DPH], q_r.sfr[IDX_DPL]} + 16'h0001;
            q_nxt.sfr[IDX_DPH] = ptr[15:8];
            q_nxt.sfr[IDX_DPL] = ptr[7:0];
         end
      end

      // a software write in the same cycle wins over the increment
      if (regWr && wrHit[5]) begin
         if (wrHit[4:0] == IDX_SEL) begin
            q_nxt.sfr[IDX_SEL] = {7'h00, regWrData[0]};
         end else begin
            q_nxt.sfr[wrHit[4:0]] = regWrData;
         end
      end

      q_nxt.rdData = 8'h00;
      if (regRd) begin
         if (rdHit[5]) begin
            q_nxt.rdData = q_r.sfr[rdHit[4:0]];
         end else if (regAddr == ccmt_pkg::CCMT_OFF_SEQ_STATUS) begin
            q_nxt.rdData = {busy, q_r.lenCnt, q_r.kind, q_r.phase};
         end
      end
   end

   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         q_r <= '0;
         q_r.ale <= 1'b1;
         q_r.sfr[IDX_P0] <= ccmt_pkg::CCMT_RST_PORT;
         q_r.sfr[IDX_P1] <= ccmt_pkg::CCMT_RST_PORT;
         q_r.sfr[IDX_P2] <= ccmt_pkg::CCMT_RST_PORT;
         q_r.sfr[IDX_CKS] <= ccmt_pkg::CCMT_RST_DEFAULT;
      end else begin
         q_r <= q_nxt;
      end
   end

   assign regRdData = q_r.rdData;
   assign ale = q_r.ale;
   assign machPhase = q_r.phase;
   assign busFetch = (q_r.kind == ccmt_pkg::CCMT_K_FETCH);
   assign busData = (q_r.kind == ccmt_pkg::CCMT_K_DATA);
   assign dptrOut = ptrSel ? {q_r.sfr[IDX_PH2], q_r.sfr[IDX_PL2]}
                           : {q_r.sfr[IDX_DPH], q_r.sfr[IDX_DPL]};

   genvar g;
   generate
      for (g = 0; g < ccmt_pkg::CCMT_TIMER_COUNT; g++) begin : gTimer
         assign timerFast[g] = q_r.sfr[IDX_CKS][ccmt_pkg::CCMT_T0_RATE_BIT + g];
         ccmt_rate_tick uTick (
            .mclk(mclk),
            .sys_rst(sys_rst),
            .fastSel(timerFast[g]),
            .tick(timerTick[g])
         );
      end
   endgenerate

   default clocking cb @(posedge mclk); endclocking
   default disable iff (sys_rst);

   a_phase_wrap: assert property ((machPhase == 2'h3) |=> (machPhase == 2'h0) ##3 (machPhase == 2'h3))
      else $error("machine cycle is not four clocks");

   a_ale_period: assert property (ale |-> (machPhase == 2'h0) ##1 (!ale) [*3] ##1 ale)
      else $error("address latch strobe not once per machine cycle");

   a_single_cycle: assert property ((take && insnBytes == 2'h1 && insnDataCyc == 2'h0 && insnIntCyc == 3'h0) |-> ##4 insnDone)
      else $error("single-cycle instruction did not end after four clocks");

   a_slow_tick: assert property ((timerTick[0] && !timerFast[0]) ##1 (!timerFast[0]) [*8] ##1 (!timerFast[0]) [*3] |=> timerTick[0])
      else $error("default timer rate is not twelve clocks");

   a_fast_tick: assert property ((timerTick[2] && timerFast[2]) ##1 timerFast[2] [*3] |=> timerTick[2])
      else $error("fast timer rate is not four clocks");

   a_external_data_move_two: assert property ((take && insnBytes == 2'h1 && insnDataCyc == 2'h1 && insnIntCyc == 3'h0) |-> ##1 busFetch [*4] ##1 busData [*4] ##0 insnDone)
      else $error("pointer data move not fetch then data in eight clocks");

   a_mov_three: assert property ((take && insnBytes == 2'h3 && insnDataCyc == 2'h0 && insnIntCyc == 3'h0) |-> ##1 (!insnDone && busFetch) [*8] ##4 insnDone)
      else $error("direct move not twelve clocks");

   a_fetch_first: assert property ((busData && $rose(busData)) |-> $past(busFetch))
      else $error("data cycle before the instruction bytes were fetched");

   a_len_bound: assert property (insnDone |-> (q_r.lenCnt >= 3'h1) && (q_r.lenCnt <= 3'h5))
      else $error("instruction length outside one to five cycles");

   a_no_dummy: assert property ((!busy) |-> (!busFetch && !busData))
      else $error("bus cycle issued with no instruction running");

   a_sel_zero: assert property ((regRd && regAddr == ccmt_pkg::CCMT_OFF_PTR_SEL) |=> (regRdData[7:1] == 7'h00))
      else $error("pointer select upper bits not zero");

   a_ptr_inc: assert property ((dptrInc && !ptrSel && !regWr) |=> (dptrOut == $past(dptrOut) + 16'h0001) || ptrSel)
      else $error("original pointer pair not advanced");

   c_external_data_move: cover property (take && insnBytes == 2'h1 && insnDataCyc == 2'h1);
   c_five: cover property (insnDone && q_r.lenCnt == 3'h5);
   c_sel_second: cover property (dptrInc && ptrSel);
   c_fast_timer: cover property (timerTick[1] && timerFast[1]);

endmodule : ccmt_core_timing

/* dv/ccmt_mem_model.sv */
`timescale 1ns/1ps
// external memory side: tallies the bus work that the core really asks for
module ccmt_mem_model (
   input wire logic mclk,
   input wire logic sys_rst,
   input wire logic ale,
   input wire logic busFetch,
   input wire logic busData,
   output logic [15:0] fetchClk,
   output logic [15:0] dataClk,
   output logic [15:0] aleCnt
);
   // counts clocks, not cycles, so a torn machine cycle shows as a stray remainder
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         fetchClk <= 16'h0000;
         dataClk <= 16'h0000;
         aleCnt <= 16'h0000;
      end else begin
         fetchClk <= fetchClk + 16'(busFetch);
         dataClk <= dataClk + 16'(busData);
         aleCnt <= aleCnt + 16'(ale);
      end
   end
endmodule : ccmt_mem_model

/* dv/core_machine_cycle_timing_test.sv */
`timescale 1ns/1ps
module core_machine_cycle_timing_test;
   logic mclk = 1'b0;
   logic sys_rst = 1'b1;
   logic [7:0] regAddr = 8'h00;
   logic [7:0] regWrData = 8'h00;
   logic regWr = 1'b0;
   logic regRd = 1'b0;
   logic [7:0] regRdData;
   logic insnStart = 1'b0;
   logic [1:0] insnBytes = 2'h0;
   logic [1:0] insnDataCyc = 2'h0;
   logic [2:0] insnIntCyc = 3'h0;
   logic insnReady, insnDone, busFetch, busData, ale, dptrInc = 1'b0;
   logic [1:0] machPhase;
   logic [15:0] dptrOut, fetchClk, dataClk, aleCnt;
   logic [2:0] timerTick;
   logic [31:0] rnd = 32'h00014294;
   logic [7:0] ra [7] = '{8'h80, 8'h90, 8'hA0, 8'h81, 8'h86, 8'h8E, 8'h92};
   logic [7:0] re [7] = '{8'hFF, 8'hFF, 8'hFF, 8'h00, 8'h00, 8'h00, 8'h00};
   int error_cnt = 0;
   int check_count = 0;

   always #2.5 mclk = ~mclk;

   ccmt_core_timing i_ccmt_core_timing (.mclk(mclk), .sys_rst(sys_rst), .regAddr(regAddr),
      .regWrData(regWrData), .regWr(regWr), .regRd(regRd), .regRdData(regRdData),
      .insnStart(insnStart), .insnBytes(insnBytes), .insnDataCyc(insnDataCyc),
      .insnIntCyc(insnIntCyc), .insnReady(insnReady), .insnDone(insnDone),
      .busFetch(busFetch), .busData(busData), .ale(ale), .machPhase(machPhase),
      .dptrInc(dptrInc), .dptrOut(dptrOut), .timerTick(timerTick));
   ccmt_mem_model i_ccmt_mem_model (.mclk(mclk), .sys_rst(sys_rst), .ale(ale),
      .busFetch(busFetch), .busData(busData), .fetchClk(fetchClk), .dataClk(dataClk),
      .aleCnt(aleCnt));

   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : lfsr

   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      check_count++;
      if (seen !== exp) begin
         error_cnt++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check

   task automatic close_out();
      $display("checks=%0d errors=%0d", check_count, error_cnt);
      if (error_cnt == 0 && check_count > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask : close_out

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge mclk);
      regAddr <= a;
      regWrData <= d;
      regWr <= 1'b1;
      @(posedge mclk);
      regWr <= 1'b0;
   endtask : wr

   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge mclk);
      regAddr <= a;
      regRd <= 1'b1;
      @(posedge mclk);
      regRd <= 1'b0;
      #1 d = regRdData;
   endtask : rd

   // clipping as the sequencer applies it: bytes 0 -> 1, data max 2, total max 5
   task automatic run_insn(input int b, input int d, input int i);
      int bb, dd, ii, cnt, f0, d0, a0;
      bb = (b == 0) ? 1 : b;
      dd = (d > 2) ? 2 : d;
      ii = (i > 5 - bb - dd) ? 5 - bb - dd : i;
      do begin @(posedge mclk); #1; end while (machPhase !== 2'h2);
      check({15'h0000, insnReady}, 16'h0000);
      @(posedge mclk);
      insnStart <= 1'b1;
      insnBytes <= 2'(b);
      insnDataCyc <= 2'(d);
      insnIntCyc <= 3'(i);
      #1 check({15'h0000, insnReady}, 16'h0001);
      @(posedge mclk);
      insnStart <= 1'b0;
      #1;
      f0 = fetchClk;
      d0 = dataClk;
      a0 = aleCnt;
      // the taking edge is the first clock of the instruction
      cnt = 1;
      while (insnDone !== 1'b1 && cnt < 30) begin
         @(posedge mclk);
         cnt++;
         #1;
      end
      check(16'(cnt), 16'(4 * (bb + dd + ii)));
      @(posedge mclk);
      #1;
      check(16'(fetchClk - f0), 16'(4 * bb));
      check(16'(dataClk - d0), 16'(4 * dd));
      check(16'(aleCnt - a0), 16'(bb + dd + ii));
   endtask : run_insn

   task automatic tmr(input int g, input logic fast);
      int n;
      wr(8'h8E, fast ? 8'(8'h01 << (3 + g)) : 8'h00);
      // first period after a rate change may be short, so time the second one
      for (int k = 0; k < 2; k++) begin
         n = 0;
         do begin @(posedge mclk); #1; n++; end while (timerTick[g] !== 1'b1 && n < 40);
      end
      check(16'(n), fast ? 16'h0004 : 16'h000C);
   endtask : tmr

   initial begin
      repeat (20000) @(posedge mclk);
      error_cnt++;
      close_out();
   end

   initial begin
      logic [7:0] v;
      logic [1:0] ph;
      logic [15:0] p0, p1, e;
      logic s;
      repeat (3) @(posedge mclk);
      sys_rst <= 1'b0;
      wr(8'h92, 8'h5A);
      for (int k = 0; k < 7; k++) begin
         rd(ra[k], v);
         check({8'h00, v}, {8'h00, re[k]});
      end
      #1 ph = machPhase;
      for (int k = 0; k < 12; k++) begin
         @(posedge mclk);
         #1;
         check({15'h0000, ale}, {15'h0000, machPhase === 2'h0});
         check({14'h0000, machPhase}, {14'h0000, ph + 2'h1});
         ph = machPhase;
      end
      for (int k = 0; k < 10; k++) begin
         rnd = lfsr(rnd);
         p0 = (k < 2) ? 16'hFFFF : rnd[15:0];
         p1 = (k < 2) ? 16'hFFFF : rnd[31:16];
         s = (k < 2) ? k[0] : rnd[7];
         wr(8'h82, p0[7:0]);
         wr(8'h83, p0[15:8]);
         wr(8'h84, p1[7:0]);
         wr(8'h85, p1[15:8]);
         wr(8'h86, {rnd[7:1], s});
         rd(8'h86, v);
         check({8'h00, v}, {15'h0000, s});
         e = s ? p1 : p0;
         check(dptrOut, e);
         @(posedge mclk);
         dptrInc <= 1'b1;
         @(posedge mclk);
         dptrInc <= 1'b0;
         #1 check(dptrOut, e + 16'h0001);
         rd(s ? 8'h85 : 8'h83, v);
         check({8'h00, v}, {8'h00, 8'((e + 16'h0001) >> 8)});
      end
      for (int g = 0; g < 3; g++) begin
         tmr(g, 1'b0);
         tmr(g, 1'b1);
      end
      run_insn(1, 1, 0);
      run_insn(3, 0, 0);
      run_insn(3, 2, 7);
      run_insn(0, 0, 0);
      run_insn(1, 3, 0);
      for (int k = 0; k < 12; k++) begin
         rnd = lfsr(rnd);
         run_insn(int'(rnd[1:0]), int'(rnd[3:2]), int'(rnd[6:4]));
      end
      close_out();
   end
endmodule : core_machine_cycle_timing_test
